// [core/cml_pkg.sv]
/*
 * Constants for the charger mode and alert logic: command codes, mode word bit positions,
 * setpoint defaults and status word bit positions.
 * Assumes a word-level command port from an SMBus front end that has already decoded the frame.
 */
`default_nettype none
package cml_pkg;
    localparam logic [7:0] CMD_MODE = 8'h12;
    localparam logic [7:0] CMD_STATUS = 8'h13;
    localparam logic [7:0] CMD_CURRENT = 8'h14;
    localparam logic [7:0] CMD_VOLTAGE = 8'h15;
    localparam logic [7:0] CMD_ALARM = 8'h16;
    localparam logic [7:0] CMD_INPUT = 8'h3F;
    localparam int MODE_CHG_OFF = 0;
    localparam int MODE_RESTORE = 2;
    localparam int MODE_ZERO = 3;
    localparam int MODE_ADP_MASK = 4;
    localparam int MODE_PACK_MASK = 5;
    localparam int MODE_LOW_MASK = 6;
    localparam int MODE_RELEARN = 8;
    localparam int MODE_HALT_EN = 10;
    localparam int ST_CHG_OFF = 0;
    localparam int ST_OVERTEMP = 10;
    localparam int ST_LOCKOUT = 12;
    localparam int ST_INPUT_LOW = 13;
    localparam int ST_PACK = 14;
    localparam int ST_ADAPTER = 15;
    localparam logic [15:0] VOLT_DEFAULT = 16'h4B00;
    localparam logic [15:0] CURR_DEFAULT = 16'h0080;
    localparam logic [15:0] INLIM_DEFAULT = 16'h0080;
    localparam logic [15:0] INLIM_MIN = 16'h0080;
    localparam logic [15:0] INLIM_KEEP = 16'h1F80;
    localparam logic [15:0] ALARM_BITS = 16'hF800;
    localparam logic [15:0] STATUS_FIXED = 16'h0010;
    localparam logic [2:0] MASK_RESET = 3'h0;
endpackage
`default_nettype wire

// [core/cml_alert.sv]
/*
 * Alert generator: watches three status flags for changes and holds the open-drain alert low.
 * Assumes the flags are synchronous to ref_clk; the host acknowledges after servicing.
 */
`timescale 1ns/1ps
`default_nettype none
module cml_alert (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [2:0] flags,
    input wire logic [2:0] masks,
    input wire logic ack,
    output logic alert_o,
    output logic alert_oe
);
    typedef struct packed {
        logic [2:0] prev;
        logic primed;
        logic pend;
    } cml_alert_st_t;
    cml_alert_st_t st_q, st_d;
    logic [2:0] changed;

    // Each flag is compared with its own previous sample in one loop.
    for (genvar i = 0; i < 3; i++) begin : g_edge
        assign changed[i] = st_q.primed && (flags[i] != st_q.prev[i]) && !masks[i];
    end

    always_comb begin
        st_d = st_q;
        st_d.prev = flags;
        st_d.primed = 1'b1;
        // A new change in the acknowledge cycle keeps the alert asserted.
        if (|changed) begin
            st_d.pend = 1'b1;
        end else if (ack) begin
            st_d.pend = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // Open drain: only ever drives low.
    assign alert_o = 1'b0;
    assign alert_oe = st_q.pend;

    chk_alert_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_q.pend && !ack |=> alert_oe) else $error("alert dropped without ack");
    chk_alert_raise: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && (|changed) |=> alert_oe) else $error("unmasked change raised no alert");
    chk_alert_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && ack && !(|changed) |=> !alert_oe) else $error("alert kept after service");
endmodule
`default_nettype wire

// [core/cml_top.sv]
/*
 * Charger mode word, setpoints, latches, source selection and alert for a smart charger.
 * Assumes an SMBus front end delivering decoded write words and read requests on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module cml_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wr_stb,
    input wire logic [7:0] wr_cmd,
    input wire logic [15:0] wr_data,
    input wire logic rd_stb,
    input wire logic [7:0] rd_cmd,
    input wire logic ara_ack,
    input wire logic adapter_detected,
    input wire logic pack_inserted,
    input wire logic input_low,
    input wire logic adapter_above_battery,
    input wire logic overtemp_detect,
    input wire logic [15:0] analog_status,
    output logic [15:0] rd_data,
    output logic [15:0] voltage_setpoint,
    output logic [15:0] current_setpoint,
    output logic [15:0] input_limit_setpoint,
    output logic charger_run,
    output logic adapter_switch_gate,
    output logic battery_switch_gate,
    output logic alert_o,
    output logic alert_oe
);
    typedef struct packed {
        logic chg_off;
        logic [2:0] masks;
        logic relearn;
        logic halt_en;
        logic overtemp;
        logic lockout;
        logic [15:0] volt;
        logic [15:0] curr;
        logic [15:0] inlim;
        logic [15:0] rdat;
    } cml_state_t;
    cml_state_t st_q, st_d;
    logic mode_wr, rd_status_ack;

    assign mode_wr = wr_stb && wr_cmd == cml_pkg::CMD_MODE;
    // Reading the status word is how the host learns the alert cause.
    assign rd_status_ack = rd_stb && rd_cmd == cml_pkg::CMD_STATUS;

    always_comb begin
        st_d = st_q;
        if (wr_stb && wr_cmd == cml_pkg::CMD_ALARM && |(wr_data & cml_pkg::ALARM_BITS)) begin
            st_d.lockout = 1'b1;
        end
        if (wr_stb && wr_cmd == cml_pkg::CMD_VOLTAGE) begin
            st_d.volt = wr_data;
            st_d.lockout = 1'b0;
        end
        if (wr_stb && wr_cmd == cml_pkg::CMD_CURRENT) begin
            st_d.curr = wr_data;
            st_d.lockout = 1'b0;
        end
        if (wr_stb && wr_cmd == cml_pkg::CMD_INPUT) begin
            // Codes at or under the minimum step clamp up, but zero stays zero.
            if (wr_data != 16'h0000 && (wr_data & cml_pkg::INLIM_KEEP) == 16'h0000) begin
                st_d.inlim = cml_pkg::INLIM_MIN;
            end else begin
                st_d.inlim = wr_data;
            end
        end
        if (mode_wr) begin
            // Bits 1, 7, 9 and 11..15 are simply never looked at.
            st_d.chg_off = wr_data[cml_pkg::MODE_CHG_OFF];
            st_d.masks = {wr_data[cml_pkg::MODE_LOW_MASK], wr_data[cml_pkg::MODE_PACK_MASK],
                          wr_data[cml_pkg::MODE_ADP_MASK]};
            st_d.relearn = wr_data[cml_pkg::MODE_RELEARN];
            st_d.halt_en = wr_data[cml_pkg::MODE_HALT_EN];
            if (wr_data[cml_pkg::MODE_RESTORE]) begin
                st_d.volt = cml_pkg::VOLT_DEFAULT;
                st_d.curr = cml_pkg::CURR_DEFAULT;
                st_d.overtemp = 1'b0;
                st_d.lockout = 1'b0;
            end
            if (wr_data[cml_pkg::MODE_ZERO]) begin
                st_d.volt = 16'h0000;
                st_d.curr = 16'h0000;
            end
        end
        // A hot reading in the restore cycle sets the latch again: the event wins over the clear.
        if (overtemp_detect) begin
            st_d.overtemp = 1'b1;
        end
        // Removal wins over the overtemp and lockout latches, halt enable and setpoints written in the same cycle.
        if (!pack_inserted) begin
            st_d.overtemp = 1'b0;
            st_d.lockout = 1'b0;
            st_d.halt_en = 1'b1;
            st_d.inlim = cml_pkg::INLIM_DEFAULT;
            st_d.volt = cml_pkg::VOLT_DEFAULT;
            st_d.curr = cml_pkg::CURR_DEFAULT;
        end
        st_d.rdat = cml_pkg::STATUS_FIXED | (analog_status & 16'h0BEC);
        st_d.rdat[cml_pkg::ST_CHG_OFF] = st_q.chg_off;
        st_d.rdat[cml_pkg::ST_OVERTEMP] = st_q.overtemp;
        st_d.rdat[cml_pkg::ST_LOCKOUT] = st_q.lockout;
        st_d.rdat[cml_pkg::ST_INPUT_LOW] = input_low;
        st_d.rdat[cml_pkg::ST_PACK] = pack_inserted;
        st_d.rdat[cml_pkg::ST_ADAPTER] = adapter_detected;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q.chg_off <= 1'b0;
            st_q.masks <= cml_pkg::MASK_RESET;
            st_q.relearn <= 1'b0;
            st_q.halt_en <= 1'b1;
            st_q.overtemp <= 1'b0;
            st_q.lockout <= 1'b0;
            st_q.volt <= cml_pkg::VOLT_DEFAULT;
            st_q.curr <= cml_pkg::CURR_DEFAULT;
            st_q.inlim <= cml_pkg::INLIM_DEFAULT;
            st_q.rdat <= cml_pkg::STATUS_FIXED;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rdat;
    assign voltage_setpoint = st_q.volt;
    assign current_setpoint = st_q.curr;
    assign input_limit_setpoint = st_q.inlim;
    // The overtemp latch only halts charging while the halt enable is set.
    assign charger_run = !st_q.chg_off && !st_q.lockout && !(st_q.halt_en && st_q.overtemp);
    // Gates are active-low switch drives: low turns the source on.
    assign adapter_switch_gate = !(adapter_above_battery && !st_q.relearn);
    assign battery_switch_gate = adapter_above_battery && !st_q.relearn;

    cml_alert u_alert (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .flags({input_low, pack_inserted, adapter_detected}),
        .masks(st_q.masks),
        .ack(ara_ack || rd_status_ack),
        .alert_o(alert_o),
        .alert_oe(alert_oe)
    );

    chk_chgoff_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && mode_wr |=>
        st_q.chg_off == $past(wr_data[cml_pkg::MODE_CHG_OFF]) && !(st_q.chg_off && charger_run))
        else $error("charge-off latch not loaded");
    chk_chgoff_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(clk_en && mode_wr) |=> st_q.chg_off == $past(st_q.chg_off)) else $error("charge-off changed");
    chk_restore_vals: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && mode_wr && wr_data[cml_pkg::MODE_RESTORE] && !wr_data[cml_pkg::MODE_ZERO] && pack_inserted |=>
        voltage_setpoint == 16'h4B00 && current_setpoint == 16'h0080 && !st_q.lockout)
        else $error("restore failed");
    chk_restore_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && mode_wr && wr_data[cml_pkg::MODE_RESTORE] && !overtemp_detect |=> !st_q.overtemp)
        else $error("restore left overtemp latch set");
    chk_overtemp_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_q.overtemp && pack_inserted && !(clk_en && mode_wr && wr_data[cml_pkg::MODE_RESTORE]) |=> st_q.overtemp)
        else $error("overtemp latch lost");
    chk_zero_vals: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && mode_wr && wr_data[cml_pkg::MODE_ZERO] && pack_inserted |=>
        voltage_setpoint == 16'h0000 && current_setpoint == 16'h0000) else $error("zero failed");
    chk_mask_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && mode_wr |=> st_q.masks == $past({wr_data[cml_pkg::MODE_LOW_MASK],
        wr_data[cml_pkg::MODE_PACK_MASK], wr_data[cml_pkg::MODE_ADP_MASK]})) else $error("masks not loaded");
    chk_relearn_gates: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_q.relearn |-> adapter_switch_gate && !battery_switch_gate) else $error("relearn gates wrong");
    chk_normal_gates: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !st_q.relearn |-> adapter_switch_gate != adapter_above_battery &&
        battery_switch_gate == adapter_above_battery) else $error("normal gates wrong");
    chk_halt_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_q.halt_en && st_q.overtemp |-> !charger_run) else $error("overtemp did not halt");
    chk_halt_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !st_q.halt_en && !st_q.chg_off && !st_q.lockout |-> charger_run) else $error("overtemp halted while disabled");
    chk_lockout_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        st_q.lockout |-> !charger_run) else $error("lockout did not stop charging");
    chk_removal_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && !pack_inserted |=> input_limit_setpoint == 16'h0080 && st_q.halt_en && !st_q.overtemp)
        else $error("removal defaults missing");
    chk_inlim_clamp: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && pack_inserted && wr_stb && wr_cmd == cml_pkg::CMD_INPUT && wr_data == 16'h0001 |=>
        input_limit_setpoint == 16'h0080) else $error("input limit not clamped");
    chk_inlim_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && pack_inserted && wr_stb && wr_cmd == cml_pkg::CMD_INPUT && |(wr_data & cml_pkg::INLIM_KEEP) |=>
        input_limit_setpoint == $past(wr_data)) else $error("input limit altered");
    chk_status_bit0: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> rd_data[0] == $past(st_q.chg_off)) else $error("status bit0 wrong");
    chk_status_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> rd_data[15:13] == $past({adapter_detected, pack_inserted, input_low}))
        else $error("status flags wrong");
    // A frozen cycle must leave every field as it was, requests included.
    chk_freeze_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !clk_en |=> st_q == $past(st_q)) else $error("state moved while clock enable low");

    cov_mode_write: cover property (@(posedge ref_clk) disable iff (!rst_n) mode_wr && wr_data[0]);
    cov_alert: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(alert_oe));
    cov_removal: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(pack_inserted));
    cov_relearn: cover property (@(posedge ref_clk) disable iff (!rst_n) st_q.relearn && adapter_above_battery);
endmodule
`default_nettype wire

// [verif/cml_host_model.sv]
/*
 * Host controller model: issues decoded write words, status reads and alert acknowledges.
 * Assumes the charger logic takes a request on the rising ref_clk edge with clk_en high.
 */
`timescale 1ns/1ps
`default_nettype none
module cml_host_model (
    input wire logic ref_clk,
    output var logic wr_stb,
    output var logic [7:0] wr_cmd,
    output var logic [15:0] wr_data,
    output var logic rd_stb,
    output var logic [7:0] rd_cmd,
    output var logic ara_ack
);
    initial begin
        wr_stb = 1'b0;
        wr_cmd = 8'h00;
        wr_data = 16'h0000;
        rd_stb = 1'b0;
        rd_cmd = 8'h00;
        ara_ack = 1'b0;
    end
    // Strobes last one edge, so a request is never taken twice.
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        wr_cmd <= cmd;
        wr_data <= data;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    // Alert response first, then the status read that tells the cause.
    task automatic service_alert();
        @(posedge ref_clk);
        ara_ack <= 1'b1;
        @(posedge ref_clk);
        ara_ack <= 1'b0;
        rd_stb <= 1'b1;
        rd_cmd <= cml_pkg::CMD_STATUS;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
    endtask
    // A hot pack can only be charged once the halt enable is cleared.
    task automatic allow_hot_charge();
        write_word(cml_pkg::CMD_MODE, 16'h0000);
    endtask
endmodule
`default_nettype wire

// [verif/test_charger_mode_and_alert_logic.sv]
/*
 * Self-checking bench for the charger mode and alert logic, driven through the host model.
 * Assumes the analog status bits stay at zero; clk_en is dropped once to check the freeze.
 */
`timescale 1ns/1ps
`default_nettype none
module test_charger_mode_and_alert_logic;
    logic ref_clk, rst_n, en, adp, pack, low, above, hot;
    logic wr_stb, rd_stb, ara_ack, run, gate_a, gate_b, alert_o, alert_oe;
    logic [7:0] wr_cmd, rd_cmd;
    logic [15:0] wr_data, rd_data, volt, curr, inlim;
    int err_total, samples_checked, cyc;
    cml_host_model i_host (.ref_clk(ref_clk), .wr_stb(wr_stb), .wr_cmd(wr_cmd), .wr_data(wr_data),
        .rd_stb(rd_stb), .rd_cmd(rd_cmd), .ara_ack(ara_ack));
    cml_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(en), .wr_stb(wr_stb), .wr_cmd(wr_cmd),
        .wr_data(wr_data), .rd_stb(rd_stb), .rd_cmd(rd_cmd), .ara_ack(ara_ack), .adapter_detected(adp),
        .pack_inserted(pack), .input_low(low), .adapter_above_battery(above), .overtemp_detect(hot),
        .analog_status(16'h0000), .rd_data(rd_data), .voltage_setpoint(volt), .current_setpoint(curr),
        .input_limit_setpoint(inlim), .charger_run(run), .adapter_switch_gate(gate_a),
        .battery_switch_gate(gate_b), .alert_o(alert_o), .alert_oe(alert_oe));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        i_host.write_word(cmd, data);
        step(3);
    endtask
    task automatic hot_pulse();
        @(posedge ref_clk) hot <= 1'b1;
        @(posedge ref_clk) hot <= 1'b0;
        step(3);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        {rst_n, adp, pack, low, above, hot} = 6'h00;
        en = 1'b1;
        step(16);
        @(posedge ref_clk) rst_n <= 1'b1;
        step(3);
        check(inlim, cml_pkg::INLIM_DEFAULT);
        check(16'(alert_oe), 16'h0000);
        $display("test reset done");
        @(posedge ref_clk) {adp, pack} <= 2'h3;
        step(3);
        check(16'(alert_oe), 16'h0001);
        check(16'(alert_o), 16'h0000);
        check(rd_data & 16'hE000, 16'hC000);
        i_host.service_alert();
        step(3);
        check(16'(alert_oe), 16'h0000);
        $display("test alert done");
        @(posedge ref_clk) en <= 1'b0;
        wr(cml_pkg::CMD_MODE, 16'h0001);
        check(16'(run), 16'h0001);
        check(rd_data & 16'h0001, 16'h0000);
        @(posedge ref_clk) en <= 1'b1;
        step(3);
        check(16'(run), 16'h0001);
        $display("test clock enable done");
        wr(cml_pkg::CMD_MODE, 16'h0401);
        check(16'(run), 16'h0000);
        check(rd_data & 16'h0001, 16'h0001);
        wr(cml_pkg::CMD_VOLTAGE, 16'h1000);
        check(rd_data & 16'h0001, 16'h0001);
        wr(cml_pkg::CMD_MODE, 16'h0400);
        check(16'(run), 16'h0001);
        check(rd_data & 16'h0001, 16'h0000);
        wr(cml_pkg::CMD_MODE, 16'h0408);
        check(volt | curr, 16'h0000);
        wr(cml_pkg::CMD_ALARM, 16'h8000);
        check(16'(run), 16'h0000);
        wr(cml_pkg::CMD_MODE, 16'h0404);
        check(volt, 16'h4B00);
        check(16'(run), 16'h0001);
        check(curr, 16'h0080);
        $display("test charge off done");
        hot_pulse();
        check(16'(run), 16'h0000);
        wr(cml_pkg::CMD_MODE, 16'h0404);
        check(16'(run), 16'h0001);
        check(rd_data & 16'h0400, 16'h0000);
        hot_pulse();
        i_host.allow_hot_charge();
        step(3);
        check(16'(run), 16'h0001);
        check(rd_data & 16'h0400, 16'h0400);
        $display("test overtemp done");
        @(posedge ref_clk) above <= 1'b1;
        wr(cml_pkg::CMD_MODE, 16'h0000);
        check({15'h0000, gate_a} | {14'h0000, gate_b, 1'b0}, 16'h0002);
        wr(cml_pkg::CMD_MODE, 16'h0100);
        check({15'h0000, gate_a} | {14'h0000, gate_b, 1'b0}, 16'h0001);
        @(posedge ref_clk) above <= 1'b0;
        wr(cml_pkg::CMD_MODE, 16'h0000);
        check({15'h0000, gate_a} | {14'h0000, gate_b, 1'b0}, 16'h0001);
        $display("test source select done");
        wr(cml_pkg::CMD_INPUT, 16'h0005);
        check(inlim, 16'h0080);
        wr(cml_pkg::CMD_INPUT, 16'h0F00);
        check(inlim, 16'h0F00);
        @(posedge ref_clk) pack <= 1'b0;
        step(3);
        @(posedge ref_clk) pack <= 1'b1;
        step(3);
        check(inlim, 16'h0080);
        check(rd_data & 16'h0400, 16'h0000);
        i_host.service_alert();
        hot_pulse();
        check(16'(run), 16'h0000);
        $display("test removal done");
        wr(cml_pkg::CMD_MODE, 16'h0454);
        @(posedge ref_clk) {adp, low} <= 2'h1;
        step(3);
        check(16'(alert_oe), 16'h0000);
        wr(cml_pkg::CMD_MODE, 16'h0400);
        @(posedge ref_clk) low <= 1'b0;
        step(3);
        check(16'(alert_oe), 16'h0001);
        i_host.service_alert();
        wr(cml_pkg::CMD_MODE, 16'h0420);
        @(posedge ref_clk) pack <= 1'b0;
        step(3);
        @(posedge ref_clk) pack <= 1'b1;
        step(3);
        check(16'(alert_oe), 16'h0000);
        wr(cml_pkg::CMD_MODE, 16'hFA82);
        check(volt, 16'h4B00);
        check(rd_data & 16'h0001, 16'h0000);
        check(16'(alert_oe), 16'h0000);
        $display("test masks done");
        summarize();
    end
endmodule
`default_nettype wire
